/* hdl/fcs_pkg.sv */
// fcs_pkg: constants and carrier types for the flash controller status register bank
package fcs_pkg;

   // bus geometry
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned ADDR_W      = 32;
   localparam int unsigned DEC_W       = 12;        // low address bits that decode the bank
   localparam int unsigned ERR_ADDR_W  = 18;

   // register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE   = 32'h4000_0810;
   localparam logic [ADDR_W-1:0] ADDR_ENGINE_STAT  = 32'h4000_0814;
   localparam logic [ADDR_W-1:0] ADDR_FETCH_STAT   = 32'h4000_0818;
   localparam logic [ADDR_W-1:0] ADDR_LOAD_STAT    = 32'h4000_081c;

   // engine status fields
   localparam int unsigned BIT_CMD_DONE     = 0;
   localparam int unsigned BIT_BAD_CMD      = 1;
   localparam int unsigned BIT_PROTECTED    = 2;
   localparam int unsigned BIT_UNLOCK_FAIL  = 3;
   localparam int unsigned BIT_ENGINE_BUSY  = 4;
   localparam int unsigned BIT_PERMIT_LO    = 5;   // key, boot, program permits at 5, 6, 7
   localparam int unsigned BIT_PERMIT_CLEAR = 8;

   // error status fields
   localparam int unsigned BIT_ERASED       = 29;
   localparam int unsigned BIT_CORRECTED    = 30;
   localparam int unsigned BIT_UNCORRECT    = 31;

   // interrupt enable fields
   localparam int unsigned IRQ_EN_W         = 8;
   localparam int unsigned IRQ_LOAD_LO      = 4;   // load erased, corrected, uncorrectable
   localparam int unsigned IRQ_FETCH_CORR   = 7;

   // reset values
   localparam logic [3:0]          RST_ENGINE_FLAGS = 4'h0;
   localparam logic [2:0]          RST_PERMITS      = 3'h0;
   localparam logic [2:0]          RST_ERR_FLAGS    = 3'h0;
   localparam logic [ERR_ADDR_W-1:0] RST_ERR_ADDR   = 18'h0_0000;
   localparam logic [IRQ_EN_W-1:0] RST_IRQ_EN       = 8'h00;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // one-cycle event reports from the command engine
   typedef struct packed {
      logic done;
      logic bad_command;
      logic protected_area;
      logic unlock_failed;
   } fcs_engine_event_type;

   // one-cycle error report from a fetch or a load path
   typedef struct packed {
      logic                  erased;
      logic                  corrected;
      logic                  uncorrectable;
      logic [ERR_ADDR_W-1:0] address;   // msb: 0 primary array, 1 auxiliary array
   } fcs_error_event_type;

   // captured error state of one path
   typedef struct packed {
      logic [2:0]            flags;     // {uncorrectable, corrected, erased}
      logic [ERR_ADDR_W-1:0] address;
   } fcs_error_state_type;

endpackage

/* hdl/fcs_status_regs.sv */
// fcs_status_regs: flash controller status, error capture and interrupt enable registers on axi4-lite
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns

// Notes on behaviour
// - command done sets bit 0, read clears
// - bad command sets bit 1, read clears
// - protected area access sets bit 2, read clears
// - failed unlock sets bit 3, read clears
// - bit 4 shows live engine busy
// - key erase allowed while locked if permitted
// - boot row write allowed if permitted
// - program row write allowed if permitted
// - writing one to bit 8 clears permits
// - fetch address holds first fetch error
// - address msb selects primary or auxiliary array
// - fetch erased read sets bit 29
// - fetch correction sets bit 30
// - fetch uncorrectable error sets bit 31
// - load address holds first load error
// - load erased read sets bit 29
// - load correction sets bit 30
// - load uncorrectable error sets bit 31
// - enabled flags drive the flash interrupt; of the fetch flags only correction has an enable
module fcs_status_regs
   import fcs_pkg::*;
(
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite write address
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   // axi4-lite write data
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   input  wire logic [DATA_W-1:0]     s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   // axi4-lite write response
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output      logic [1:0]            s_axi_bresp,
   // axi4-lite read address
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   // axi4-lite read data
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output      logic [DATA_W-1:0]     s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   // command engine side
   input  wire fcs_engine_event_type  engine_event,
   input  wire logic                  engine_busy,
   input  wire logic                  flash_locked,
   input  wire logic [2:0]            permit_set,
   output      logic                  key_erase_allow,
   output      logic                  boot_write_allow,
   output      logic                  program_write_allow,
   // read path error reports
   input  wire fcs_error_event_type   fetch_event,
   input  wire fcs_error_event_type   load_event,
   // interrupt
   output      logic                  flash_irq
);

   // register state
   logic [3:0]            engine_flags;
   logic [2:0]            permits;          // {program, boot, key}
   logic [IRQ_EN_W-1:0]   irq_enable;
   fcs_error_state_type   fetch_state;
   fcs_error_state_type   load_state;

   // write channel holding
   logic                  aw_held;
   logic                  w_held;
   logic [DEC_W-1:0]      aw_addr;
   logic [DATA_W-1:0]     w_data;
   logic [3:0]            w_strb;

   // decoded strobes
   logic                  wr_fire;
   logic                  rd_fire;
   logic                  rd_engine;
   logic                  rd_fetch;
   logic                  rd_load;
   logic [3:0]            engine_set;
   logic [2:0]            fetch_set;
   logic [2:0]            load_set;
   logic [DATA_W-1:0]     next_rdata;
   logic                  next_rvalid_err;

   // write: address and data accepted independently, one write in flight
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

   // capture write address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr[DEC_W-1:0];
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   // capture write data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   // write response; unmapped addresses answer slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr[DEC_W-1:2] >= ADDR_IRQ_ENABLE[DEC_W-1:2] &&
                          aw_addr[DEC_W-1:2] <= ADDR_LOAD_STAT[DEC_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // interrupt enables; only byte lane 0 holds bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_enable <= RST_IRQ_EN;
      end else if (wr_fire && w_strb[0] && aw_addr[DEC_W-1:2] == ADDR_IRQ_ENABLE[DEC_W-1:2]) begin
         irq_enable <= w_data[IRQ_EN_W-1:0];
      end
   end

   // read: one read in flight, the clearing side effect happens at acceptance
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;
   assign rd_engine     = rd_fire && s_axi_araddr[DEC_W-1:2] == ADDR_ENGINE_STAT[DEC_W-1:2];
   assign rd_fetch      = rd_fire && s_axi_araddr[DEC_W-1:2] == ADDR_FETCH_STAT[DEC_W-1:2];
   assign rd_load       = rd_fire && s_axi_araddr[DEC_W-1:2] == ADDR_LOAD_STAT[DEC_W-1:2];

   // read data mux, reserved bits zero
   always_comb begin
      next_rdata      = '0;
      next_rvalid_err = 1'b0;
      unique case (s_axi_araddr[DEC_W-1:2])
         ADDR_IRQ_ENABLE[DEC_W-1:2]: begin
            next_rdata[IRQ_EN_W-1:0] = irq_enable;
         end
         ADDR_ENGINE_STAT[DEC_W-1:2]: begin
            next_rdata[BIT_UNLOCK_FAIL:BIT_CMD_DONE]  = engine_flags;
            next_rdata[BIT_ENGINE_BUSY]               = engine_busy;
            next_rdata[BIT_PERMIT_LO+2:BIT_PERMIT_LO] = permits;
         end
         ADDR_FETCH_STAT[DEC_W-1:2]: begin
            next_rdata[ERR_ADDR_W-1:0]            = fetch_state.address;
            next_rdata[BIT_UNCORRECT:BIT_ERASED]  = fetch_state.flags;
         end
         ADDR_LOAD_STAT[DEC_W-1:2]: begin
            next_rdata[ERR_ADDR_W-1:0]            = load_state.address;
            next_rdata[BIT_UNCORRECT:BIT_ERASED]  = load_state.flags;
         end
         default: begin
            next_rvalid_err = 1'b1;
         end
      endcase
   end

   // read data register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rvalid_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // event vectors in register bit order
   assign engine_set = {engine_event.unlock_failed, engine_event.protected_area,
                        engine_event.bad_command, engine_event.done};
   assign fetch_set  = {fetch_event.uncorrectable, fetch_event.corrected, fetch_event.erased};
   assign load_set   = {load_event.uncorrectable, load_event.corrected, load_event.erased};

   // read-clear flags; set term or-ed after the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         engine_flags <= RST_ENGINE_FLAGS;
      end else begin
         engine_flags <= (engine_flags & {4{!rd_engine}}) | engine_set;
      end
   end

   // permit clear, a simultaneous set still wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         permits <= RST_PERMITS;
      end else begin
         if (wr_fire && w_strb[1] && w_data[BIT_PERMIT_CLEAR] &&
             aw_addr[DEC_W-1:2] == ADDR_ENGINE_STAT[DEC_W-1:2]) begin
            permits <= permit_set;
         end else begin
            permits <= permits | permit_set;
         end
      end
   end

   assign key_erase_allow     = !flash_locked || permits[0];
   assign boot_write_allow    = !flash_locked || permits[1];
   assign program_write_allow = !flash_locked || permits[2];

   // fetch flags; first-error address, msb is the array select
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fetch_state.flags   <= RST_ERR_FLAGS;
         fetch_state.address <= RST_ERR_ADDR;
      end else begin
         fetch_state.flags <= (fetch_state.flags & {3{!rd_fetch}}) | fetch_set;
         // a read in the same cycle empties the flags, so a new error recaptures
         if (|fetch_set && (fetch_state.flags == 3'h0 || rd_fetch)) begin
            fetch_state.address <= fetch_event.address;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_state.flags   <= RST_ERR_FLAGS;
         load_state.address <= RST_ERR_ADDR;
      end else begin
         load_state.flags <= (load_state.flags & {3{!rd_load}}) | load_set;
         if (|load_set && (load_state.flags == 3'h0 || rd_load)) begin
            load_state.address <= load_event.address;
         end
      end
   end

   // gated interrupt; built from flops only, so no glitch path from the bus
   assign flash_irq = |(engine_flags & irq_enable[3:0]) |
                      |(load_state.flags & irq_enable[IRQ_LOAD_LO+2:IRQ_LOAD_LO]) |
                      (fetch_state.flags[1] & irq_enable[IRQ_FETCH_CORR]);

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // engine flags: set by the event, kept until a read takes them
   property p_done_set;
      engine_event.done || (engine_flags[BIT_CMD_DONE] && !rd_engine) |=> engine_flags[BIT_CMD_DONE];
   endproperty

   property p_engine_clear;
      rd_engine && engine_set == 4'h0 |=> engine_flags == 4'h0;
   endproperty

   property p_busy_read;
      rd_engine |=> s_axi_rdata[BIT_ENGINE_BUSY] == $past(engine_busy);
   endproperty

   // lock bypass follows the permit bits while locked
   property p_key_bypass;
      flash_locked && permits[0] |-> key_erase_allow;
   endproperty

   property p_prog_bypass;
      flash_locked |-> program_write_allow == permits[2] && boot_write_allow == permits[1];
   endproperty

   property p_permit_clear;
      wr_fire && w_strb[1] && w_data[BIT_PERMIT_CLEAR] && aw_addr[DEC_W-1:2] == ADDR_ENGINE_STAT[DEC_W-1:2]
         && permit_set == 3'h0 |=> permits == 3'h0;
   endproperty

   // error paths: first address kept, each event sets its flag
   property p_fetch_addr_hold;
      fetch_state.flags != 3'h0 && !rd_fetch |=> $stable(fetch_state.address);
   endproperty

   property p_fetch_capture;
      fetch_state.flags == 3'h0 && fetch_event.uncorrectable |=>
         fetch_state.address == $past(fetch_event.address) && fetch_state.flags[2];
   endproperty

   property p_fetch_erased;
      fetch_event.erased |=> fetch_state.flags[0];
   endproperty

   property p_fetch_corr;
      fetch_event.corrected |=> fetch_state.flags[1];
   endproperty

   property p_fetch_uncorr;
      fetch_event.uncorrectable |=> fetch_state.flags[2];
   endproperty

   property p_load_capture;
      load_state.flags == 3'h0 && |load_set |=> load_state.address == $past(load_event.address);
   endproperty

   property p_load_erased;
      load_event.erased && !rd_load ##1 !rd_load |=> load_state.flags[0];
   endproperty

   property p_load_corr;
      load_event.corrected |=> load_state.flags[1];
   endproperty

   property p_irq_gate;
      engine_flags[BIT_BAD_CMD] && irq_enable[BIT_BAD_CMD] |-> flash_irq;
   endproperty

   property p_set_wins;
      rd_engine && engine_event.unlock_failed |=> engine_flags[BIT_UNLOCK_FAIL] && s_axi_rvalid;
   endproperty

   property p_load_clear;
      rd_load && load_set == 3'h0 |=> load_state.flags == 3'h0 ##1 $stable(load_state.address) || |$past(load_set);
   endproperty

   a_done_set:        assert property (p_done_set)        else $error("done flag not held until read");
   a_engine_clear:    assert property (p_engine_clear)    else $error("engine flags not cleared by read");
   a_busy_read:       assert property (p_busy_read)       else $error("busy bit not live");
   a_key_bypass:      assert property (p_key_bypass)      else $error("key erase bypass missing");
   a_permit_clear:    assert property (p_permit_clear)    else $error("permits not cleared");
   a_fetch_addr_hold: assert property (p_fetch_addr_hold) else $error("fetch address overwritten");
   a_fetch_capture:   assert property (p_fetch_capture)   else $error("fetch first address wrong");
   a_load_erased:     assert property (p_load_erased)     else $error("load erased flag lost");
   a_irq_gate:        assert property (p_irq_gate)        else $error("enabled flag not on irq");
   a_set_wins:        assert property (p_set_wins)        else $error("event lost on clearing read");
   a_load_clear:      assert property (p_load_clear)      else $error("load flags not cleared by read");
   a_prog_bypass:     assert property (p_prog_bypass)     else $error("row write bypass wrong");
   a_fetch_erased:    assert property (p_fetch_erased)    else $error("fetch erased flag not set");
   a_fetch_corr:      assert property (p_fetch_corr)      else $error("fetch corrected flag not set");
   a_fetch_uncorr:    assert property (p_fetch_uncorr)    else $error("fetch uncorrectable flag not set");
   a_load_capture:    assert property (p_load_capture)    else $error("load first address wrong");
   a_load_corr:       assert property (p_load_corr)       else $error("load corrected flag not set");

   c_engine_read:  cover property (engine_flags[BIT_CMD_DONE] ##1 rd_engine);
   c_fetch_error:  cover property (fetch_event.corrected ##[1:20] rd_fetch);
   c_collision:    cover property (rd_load && |load_set);
   c_irq:          cover property (!flash_irq ##1 flash_irq);
   c_permit_clr:   cover property (wr_fire && w_data[BIT_PERMIT_CLEAR]);

endmodule // fcs_status_regs

/* tb/fcs_axi_master.sv */
// fcs_axi_master: axi4-lite master model standing in for the processor core
`timescale 1ns/1ns
module fcs_axi_master
   import fcs_pkg::*;
(
   // clock
   input  wire logic              aclk,
   // write channels
   output      logic              s_axi_awvalid,
   input  wire logic              s_axi_awready,
   output      logic [ADDR_W-1:0] s_axi_awaddr,
   output      logic              s_axi_wvalid,
   input  wire logic              s_axi_wready,
   output      logic [DATA_W-1:0] s_axi_wdata,
   output      logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_bvalid,
   output      logic              s_axi_bready,
   input  wire logic [1:0]        s_axi_bresp,
   // read channels
   output      logic              s_axi_arvalid,
   input  wire logic              s_axi_arready,
   output      logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_rvalid,
   output      logic              s_axi_rready,
   input  wire logic [DATA_W-1:0] s_axi_rdata,
   input  wire logic [1:0]        s_axi_rresp
);
   // idle bus at time zero
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'h0;
   end

   // address and data offered together, each dropped once taken
   task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] s,
                        output logic [1:0] r);
      bit aw_p;
      bit w_p;
      @(posedge aclk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_bready  <= 1'b1;
      aw_p = 1'b1;
      w_p = 1'b1;
      while (aw_p || w_p) begin
         @(posedge aclk);
         // released address and data lines never keep the old value
         if (aw_p && s_axi_awready) begin
            aw_p = 1'b0;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~a;
         end
         if (w_p && s_axi_wready) begin
            w_p = 1'b0;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~d;
         end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // one read, rready held until data arrive
   task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr  <= ~a;
      while (!s_axi_rvalid) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule // fcs_axi_master

/* tb/tb_top.sv */
// tb_top: self-checking bench for the flash controller status register bank
`timescale 1ns/1ns
module tb_top
   import fcs_pkg::*;
;
   logic                 aclk;
   logic                 aresetn;
   logic                 awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [ADDR_W-1:0]    awaddr, araddr;
   logic [DATA_W-1:0]    wdata, rdata;
   logic [3:0]           wstrb;
   logic [1:0]           bresp, rresp;
   fcs_engine_event_type engine_event;
   fcs_error_event_type  fetch_event, load_event;
   logic                 engine_busy, flash_locked, key_allow, boot_allow, prog_allow, flash_irq;
   logic [2:0]           permit_set;
   // bench view of what the registers should hold
   logic [3:0]           eng_m;
   logic [2:0]           perm_m;
   fcs_error_state_type  fst, lst;
   int                   miscompares;
   int                   checks;

   // 100 ns clock
   initial aclk = 1'b0;
   always #50 aclk = ~aclk;

   fcs_status_regs dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .engine_event(engine_event), .engine_busy(engine_busy), .flash_locked(flash_locked),
      .permit_set(permit_set), .key_erase_allow(key_allow), .boot_write_allow(boot_allow),
      .program_write_allow(prog_allow), .fetch_event(fetch_event), .load_event(load_event),
      .flash_irq(flash_irq));

   fcs_axi_master mst_u (.aclk(aclk),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

   // first error captures the address, later ones only add flags
   function automatic fcs_error_state_type err_upd(fcs_error_state_type s, fcs_error_event_type e);
      logic [2:0] f;
      f = {e.uncorrectable, e.corrected, e.erased};
      if (f != 3'h0 && s.flags == 3'h0) s.address = e.address;
      s.flags = s.flags | f;
      return s;
   endfunction

   // expected error word; the address stays readable once the flags clear
   function automatic logic [33:0] err_exp(fcs_error_state_type s);
      return {2'h0, s.flags, 11'h0, s.address};
   endfunction

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one cycle of event inputs, then the model follows
   task automatic pulse(input fcs_engine_event_type e, input fcs_error_event_type f, l, input logic [2:0] p);
      @(posedge aclk);
      engine_event <= e;
      fetch_event  <= f;
      load_event   <= l;
      permit_set   <= p;
      @(posedge aclk);
      engine_event <= '0;
      fetch_event  <= '0;
      load_event   <= '0;
      permit_set   <= '0;
      eng_m  = eng_m | {e.unlock_failed, e.protected_area, e.bad_command, e.done};
      perm_m = perm_m | p;
      fst = err_upd(fst, f);
      lst = err_upd(lst, l);
   endtask

   // read a status register, compare, then apply the read-clear
   task automatic rd_chk(input logic [31:0] a);
      logic [31:0] d;
      logic [1:0]  r;
      mst_u.read(a, d, r);
      if (a == ADDR_ENGINE_STAT) begin
         check({2'h0, d}, {26'h0, perm_m, engine_busy, eng_m});
         eng_m = 4'h0;
      end else if (a == ADDR_FETCH_STAT) begin
         check({2'h0, d}, err_exp(fst));
         fst.flags = 3'h0;
      end else begin
         check({2'h0, d}, err_exp(lst));
         lst.flags = 3'h0;
      end
      check({32'h0, r}, {32'h0, RESP_OKAY});
   endtask

   task automatic allow_chk;
      @(negedge aclk);
      check({31'h0, prog_allow, boot_allow, key_allow}, {31'h0, flash_locked ? perm_m : 3'h7});
   endtask

   task final_report;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // hang guard, well beyond the expected run length
   initial begin
      repeat (30000) @(posedge aclk);
      miscompares++;
      final_report;
   end

   initial begin
      logic [31:0]         d;
      logic [31:0]         rv;
      logic [1:0]          r;
      fcs_error_event_type f;
      fcs_error_event_type l;
      fcs_error_state_type pre;
      {aresetn, engine_busy, flash_locked, permit_set} = 6'h0;
      {engine_event, fetch_event, load_event} = '0;
      {eng_m, perm_m, fst, lst} = '0;
      miscompares = 0;
      checks = 0;
      void'($urandom(54758));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values and two unmapped places
      rd_chk(ADDR_ENGINE_STAT);
      rd_chk(ADDR_FETCH_STAT);
      rd_chk(ADDR_LOAD_STAT);
      mst_u.read(ADDR_IRQ_ENABLE, d, r);
      check({r, d}, {RESP_OKAY, 32'h0});
      mst_u.write(32'h4000_0820, 32'hffff_ffff, 4'hf, r);
      check({32'h0, r}, {32'h0, RESP_SLVERR});
      mst_u.read(32'h4000_0800, d, r);
      check({r, d}, {RESP_SLVERR, 32'h0});
      $display("test reset done");
      // each engine flag sets, then a second read finds it cleared
      engine_busy <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         pulse(4'h8 >> i, '0, '0, 3'h0);
         rd_chk(ADDR_ENGINE_STAT);
         rd_chk(ADDR_ENGINE_STAT);
      end
      // permits while locked, zero at bit 8 is harmless, one clears all three
      flash_locked <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         pulse('0, '0, '0, 3'h1 << i);
         allow_chk;
      end
      mst_u.write(ADDR_ENGINE_STAT, 32'hffff_feff, 4'hf, r);
      rd_chk(ADDR_ENGINE_STAT);
      mst_u.write(ADDR_ENGINE_STAT, 32'h0000_0100, 4'h2, r);
      check({32'h0, r}, {32'h0, RESP_OKAY});
      perm_m = 3'h0;
      rd_chk(ADDR_ENGINE_STAT);
      allow_chk;
      flash_locked <= 1'b0;
      allow_chk;
      $display("test permits done");
      // random events on every path, reads scattered among them
      for (int n = 0; n < 80; n++) begin
         rv = $urandom;
         f = rv[20:0];
         rv = $urandom;
         l = rv[20:0];
         rv = $urandom;
         engine_busy  <= rv[18];
         flash_locked <= rv[19];
         pulse(rv[3:0] & rv[7:4], rv[20] ? f : '0, rv[21] ? l : '0, rv[10:8] & rv[13:11]);
         allow_chk;
         case (rv[17:16])
            2'h0: rd_chk(ADDR_ENGINE_STAT);
            2'h1: rd_chk(ADDR_FETCH_STAT);
            2'h2: rd_chk(ADDR_LOAD_STAT);
            default: ;
         endcase
      end
      $display("test random done");
      // event on the very edge of the clearing read survives
      rv = $urandom;
      f = rv[20:0];
      f.erased = 1'b1;
      pre = fst;
      fork
         mst_u.read(ADDR_FETCH_STAT, d, r);
         pulse('0, f, '0, 3'h0);
      join
      check({2'h0, d}, err_exp(pre));
      fst = err_upd('{flags: 3'h0, address: pre.address}, f);
      rd_chk(ADDR_FETCH_STAT);
      $display("test set wins done");
      // each enable gates its own flag onto the interrupt line
      for (int i = 0; i < 8; i++) begin
         rv = $urandom;
         l = '0;
         f = '0;
         {l.erased, l.corrected, l.uncorrectable} = 3'h4 >> (i - 4);
         l.address = rv[17:0];
         f.corrected = (i == 7);
         f.address = rv[17:0];
         pulse((i < 4) ? 4'h8 >> i : 4'h0, f, (i > 3 && i < 7) ? l : '0, 3'h0);
         @(negedge aclk);
         check({33'h0, flash_irq}, 34'h0);
         mst_u.write(ADDR_IRQ_ENABLE, 32'h1 << i, 4'h1, r);
         @(negedge aclk);
         check({33'h0, flash_irq}, 34'h1);
         mst_u.write(ADDR_IRQ_ENABLE, 32'h0, 4'h1, r);
         @(negedge aclk);
         check({33'h0, flash_irq}, 34'h0);
         rd_chk((i < 4) ? ADDR_ENGINE_STAT : (i < 7) ? ADDR_LOAD_STAT : ADDR_FETCH_STAT);
      end
      $display("test interrupt done");
      final_report;
   end
endmodule // tb_top
